// file: include/acet_pkg.sv
/*
 * constants, field layout and carrier types for the compare-event
 * triggered converter control block.
 * assumes one system clock; the compare unit and timers share it.
 */
package acet_pkg;

    // ============================================================
    // widths
    localparam int DATA_W   = 8;
    localparam int ADDR_W   = 4;
    localparam int RESULT_W = 10;

    typedef logic [ADDR_W-1:0]   acet_addr_t;
    typedef logic [DATA_W-1:0]   acet_byte_t;
    typedef logic [RESULT_W-1:0] acet_result_t;

    // ============================================================
    // register offsets
    localparam acet_addr_t OFS_CHANNEL   = 4'h0;
    localparam acet_addr_t OFS_REFERENCE = 4'h1;
    localparam acet_addr_t OFS_TIMING    = 4'h2;
    localparam acet_addr_t OFS_RES_HIGH  = 4'h3;
    localparam acet_addr_t OFS_RES_LOW   = 4'h4;
    localparam acet_addr_t OFS_IRQ_FLAGS = 4'h5;
    localparam acet_addr_t OFS_IRQ_EN    = 4'h6;
    localparam acet_addr_t OFS_IRQ_PRIO  = 4'h7;
    localparam acet_addr_t OFS_TRIGGER   = 4'h8;

    // ============================================================
    // field positions
    localparam int CHAN_LSB = 2;
    localparam int CHAN_W   = 4;
    localparam int GO_BIT   = 1;
    localparam int EN_BIT   = 0;
    localparam int VREF_LSB = 4;
    localparam int VREF_W   = 2;
    localparam int PCFG_LSB = 0;
    localparam int PCFG_W   = 4;
    localparam int JUST_BIT = 7;
    localparam int ACQ_LSB  = 3;
    localparam int SEL_W    = 3;
    localparam int CLKS_LSB = 0;
    localparam int IRQ_BIT  = 6;
    localparam int TSEL_BIT = 0;

    // ============================================================
    // codes and reset values
    localparam logic [3:0] SPECIAL_EVENT_CODE = 4'hB;
    localparam acet_byte_t REG_RESET          = 8'h00;
    localparam acet_byte_t READ_ZERO          = 8'h00;
    localparam logic [1:0] RST_SYNC_INIT      = 2'h0;

    // ============================================================
    // sequencer defaults
    localparam int CONV_TADS    = 11;
    localparam int ACQ_TAD_STEP = 2;
    localparam int CLK_DIV_BASE = 2;
    localparam int DIV_W        = 9;
    localparam int TAD_W        = 5;

    // ============================================================
    // carriers
    typedef struct packed {
        logic       wr;
        logic       rd;
        acet_addr_t addr;
        acet_byte_t wdata;
    } acet_bus_s;

    typedef struct packed {
        logic       special_event;
        logic [3:0] compare_mode_field;
    } acet_cmp_s;

    typedef struct packed {
        logic [CHAN_W-1:0] channel_select;
        logic [VREF_W-1:0] voltage_reference_select;
        logic [PCFG_W-1:0] port_analog_config;
        logic              sampling;
        logic              converter_enable;
    } acet_analog_s;

endpackage : acet_pkg

// file: logic/acet_seq.sv
/*
 * acquisition then conversion sequencer, timed in converter clock periods.
 * assumes start and abort are single-cycle pulses on the same clock.
 */
`timescale 1ns/10ps
module acet_seq #(
    parameter int CONV_TADS    = acet_pkg::CONV_TADS,
    parameter int ACQ_TAD_STEP = acet_pkg::ACQ_TAD_STEP
) (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst_sync_n,
    // control
    input  wire logic                     start,
    input  wire logic                     abort,
    input  wire logic [acet_pkg::SEL_W-1:0] acq_sel,
    input  wire logic [acet_pkg::SEL_W-1:0] clk_sel,
    // status
    output logic                          sampling,
    output logic                          done
);
    typedef enum logic [1:0] {ACET_IDLE, ACET_ACQ, ACET_CONV} acet_seq_e;

    typedef struct packed {
        acet_seq_e                    st;
        logic [acet_pkg::DIV_W-1:0]   div;
        logic [acet_pkg::TAD_W-1:0]   tad;
        logic                         done;
    } acet_seq_s;

    acet_seq_s s_r;
    acet_seq_s s_nxt;
    logic [acet_pkg::DIV_W-1:0] tad_len;
    logic [acet_pkg::TAD_W-1:0] acq_tads;
    logic [acet_pkg::TAD_W-1:0] target;

    assign tad_len  = acet_pkg::DIV_W'(acet_pkg::CLK_DIV_BASE) << clk_sel;
    assign acq_tads = acet_pkg::TAD_W'(acq_sel) * acet_pkg::TAD_W'(ACQ_TAD_STEP);
    assign target   = (s_r.st == ACET_ACQ) ? acq_tads : acet_pkg::TAD_W'(CONV_TADS);

    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        case (s_r.st)
            ACET_IDLE: begin
                s_nxt.div = '0;
                s_nxt.tad = '0;
                // zero acquisition goes straight to conversion
                if (start) begin
                    s_nxt.st = (acq_tads == '0) ? ACET_CONV : ACET_ACQ;
                end
            end
            default: begin
                if (s_r.div == tad_len - 1'b1) begin
                    s_nxt.div = '0;
                    s_nxt.tad = s_r.tad + 1'b1;
                    if (s_r.tad == target - 1'b1) begin
                        s_nxt.tad  = '0;
                        s_nxt.st   = (s_r.st == ACET_ACQ) ? ACET_CONV : ACET_IDLE;
                        s_nxt.done = (s_r.st == ACET_CONV);
                    end
                end else begin
                    s_nxt.div = s_r.div + 1'b1;
                end
            end
        endcase
        // abort drops the conversion without a done pulse
        if (abort) begin
            s_nxt.st   = ACET_IDLE;
            s_nxt.done = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_r <= '{st: ACET_IDLE, div: '0, tad: '0, done: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sampling = (s_r.st == ACET_ACQ);
    assign done     = s_r.done;

endmodule : acet_seq

// file: logic/acet_fmt.sv
/*
 * result register pair with left or right justification.
 * assumes load is a one-cycle pulse; a load beats a software write.
 */
`timescale 1ns/10ps
module acet_fmt (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_sync_n,
    // conversion side
    input  wire logic                   load,
    input  wire logic                   justify_right,
    input  wire acet_pkg::acet_result_t raw,
    // software side
    input  wire logic                   wr_high,
    input  wire logic                   wr_low,
    input  wire acet_pkg::acet_byte_t   wdata,
    // result bytes
    output acet_pkg::acet_byte_t        result_high,
    output acet_pkg::acet_byte_t        result_low
);
    typedef struct packed {
        acet_pkg::acet_byte_t high;
        acet_pkg::acet_byte_t low;
    } acet_fmt_s;

    acet_fmt_s s_r;
    acet_fmt_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (wr_high) begin
            s_nxt.high = wdata;
        end
        if (wr_low) begin
            s_nxt.low = wdata;
        end
        if (load) begin
            if (justify_right) begin
                s_nxt.high = {6'h00, raw[9:8]};
                s_nxt.low  = raw[7:0];
            end else begin
                s_nxt.high = raw[9:2];
                s_nxt.low  = {raw[1:0], 6'h00};
            end
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_r <= '{high: acet_pkg::REG_RESET, low: acet_pkg::REG_RESET};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign result_high = s_r.high;
    assign result_low  = s_r.low;

endmodule : acet_fmt

// file: logic/acet_top.sv
/*
 * converter control with compare special event trigger: registers,
 * trigger qualification, timer clear and conversion completion.
 * assumes the compare unit, timers and analog front end run on clock.
 */
// Notes on behaviour
// - trigger accepted only in mode 1011, enabled
// - accepted trigger sets go flag, starts conversion unless one is running
// - every trigger clears selected timer counter
// - disabled converter ignores trigger, timer still cleared
// - channel, go flag, enable in first control
// - reference and port config in second control
// - justify, acquisition, clock select in third control
// - interrupt flag, enable, priority at bit six
// - unimplemented register bits read as zero
`timescale 1ns/10ps
module acet_top #(
    parameter int CONV_TADS    = acet_pkg::CONV_TADS,
    parameter int ACQ_TAD_STEP = acet_pkg::ACQ_TAD_STEP
) (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    // register port
    input  wire acet_pkg::acet_bus_s    bus,
    output acet_pkg::acet_byte_t        rd_data,
    // compare unit
    input  wire acet_pkg::acet_cmp_s    cmp,
    // timers
    output logic                        first_timer_clear,
    output logic                        third_timer_clear,
    // analog front end
    input  wire acet_pkg::acet_result_t sample_data,
    output acet_pkg::acet_analog_s      analog,
    // interrupt request level
    output logic                        irq_request,
    output logic                        irq_high_priority
);
    // ============================================================
    // reset release
    logic [1:0] rst_sync_r;
    logic       rst_sync_n;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= acet_pkg::RST_SYNC_INIT;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    assign rst_sync_n = rst_sync_r[1];

    // ============================================================
    // decode helper
    function automatic logic acet_hit(input logic strobe,
                                      input acet_pkg::acet_addr_t addr,
                                      input acet_pkg::acet_addr_t ofs);
        acet_hit = strobe && (addr == ofs);
    endfunction : acet_hit

    // ============================================================
    // state
    typedef struct packed {
        logic [acet_pkg::CHAN_W-1:0] chan;
        logic                        go;
        logic                        en;
        logic [acet_pkg::VREF_W-1:0] vref;
        logic [acet_pkg::PCFG_W-1:0] pcfg;
        logic                        just;
        logic [acet_pkg::SEL_W-1:0]  acq;
        logic [acet_pkg::SEL_W-1:0]  clks;
        logic                        irq_flag;
        logic                        irq_en;
        logic                        irq_prio;
        logic                        trig_sel;
        acet_pkg::acet_byte_t        rdata;
        logic                        clr1;
        logic                        clr3;
        logic                        start;
        logic                        abort;
    } acet_top_s;

    acet_top_s s_r;
    acet_top_s s_nxt;

    logic                 seq_sampling;
    logic                 seq_done;
    acet_pkg::acet_byte_t res_high;
    acet_pkg::acet_byte_t res_low;
    logic                 wr_chan;
    logic                 wr_ref;
    logic                 wr_tim;
    logic                 wr_flags;
    logic                 wr_ien;
    logic                 wr_iprio;
    logic                 wr_trig;
    logic                 event_valid;
    logic                 trig_accept;
    logic                 sw_go;
    logic                 en_after;

    assign wr_chan  = acet_hit(bus.wr, bus.addr, acet_pkg::OFS_CHANNEL);
    assign wr_ref   = acet_hit(bus.wr, bus.addr, acet_pkg::OFS_REFERENCE);
    assign wr_tim   = acet_hit(bus.wr, bus.addr, acet_pkg::OFS_TIMING);
    assign wr_flags = acet_hit(bus.wr, bus.addr, acet_pkg::OFS_IRQ_FLAGS);
    assign wr_ien   = acet_hit(bus.wr, bus.addr, acet_pkg::OFS_IRQ_EN);
    assign wr_iprio = acet_hit(bus.wr, bus.addr, acet_pkg::OFS_IRQ_PRIO);
    assign wr_trig  = acet_hit(bus.wr, bus.addr, acet_pkg::OFS_TRIGGER);

    // ============================================================
    // trigger qualification
    // the event only exists as a trigger while the compare unit sits in
    // special event mode; in other modes the pulse means nothing here
    assign event_valid = cmp.special_event &&
                         (cmp.compare_mode_field == acet_pkg::SPECIAL_EVENT_CODE);
    assign trig_accept = event_valid && s_r.en;

    // enable as it stands after this cycle's write, so one write may
    // switch the converter on and start it together
    assign en_after = wr_chan ? bus.wdata[acet_pkg::EN_BIT] : s_r.en;
    assign sw_go    = wr_chan && bus.wdata[acet_pkg::GO_BIT] && en_after;

    always_comb begin
        s_nxt       = s_r;
        s_nxt.start = 1'b0;
        s_nxt.abort = 1'b0;
        s_nxt.clr1  = 1'b0;
        s_nxt.clr3  = 1'b0;

        // ========================================================
        // software writes
        // first control fields
        if (wr_chan) begin
            s_nxt.chan = bus.wdata[acet_pkg::CHAN_LSB +: acet_pkg::CHAN_W];
            s_nxt.en   = bus.wdata[acet_pkg::EN_BIT];
            s_nxt.go   = bus.wdata[acet_pkg::GO_BIT] && en_after;
        end
        if (wr_ref) begin
            s_nxt.vref = bus.wdata[acet_pkg::VREF_LSB +: acet_pkg::VREF_W];
            s_nxt.pcfg = bus.wdata[acet_pkg::PCFG_LSB +: acet_pkg::PCFG_W];
        end
        if (wr_tim) begin
            s_nxt.just = bus.wdata[acet_pkg::JUST_BIT];
            s_nxt.acq  = bus.wdata[acet_pkg::ACQ_LSB +: acet_pkg::SEL_W];
            s_nxt.clks = bus.wdata[acet_pkg::CLKS_LSB +: acet_pkg::SEL_W];
        end
        if (wr_ien) begin
            s_nxt.irq_en = bus.wdata[acet_pkg::IRQ_BIT];
        end
        if (wr_iprio) begin
            s_nxt.irq_prio = bus.wdata[acet_pkg::IRQ_BIT];
        end
        if (wr_flags) begin
            s_nxt.irq_flag = bus.wdata[acet_pkg::IRQ_BIT];
        end
        if (wr_trig) begin
            s_nxt.trig_sel = bus.wdata[acet_pkg::TSEL_BIT];
        end

        // ========================================================
        // conversion end
        // done clears go
        if (seq_done) begin
            s_nxt.go       = 1'b0;
            s_nxt.irq_flag = 1'b1;
        end

        // ========================================================
        // starts; a trigger set beats a clear in the same cycle
        // hardware sets go
        if (trig_accept) begin
            s_nxt.go = 1'b1;
        end
        if (trig_accept || sw_go) begin
            // a busy converter keeps its running conversion
            s_nxt.start = !s_r.go || seq_done;
        end

        // a cleared go or enable with no new start stops the sequencer
        s_nxt.abort = s_r.go && !s_nxt.go && !seq_done;

        if (event_valid) begin
            s_nxt.clr1 = !s_r.trig_sel;
            s_nxt.clr3 = s_r.trig_sel;
        end

        // ========================================================
        // read data, valid the cycle after the strobe
        // unimplemented bits zero
        s_nxt.rdata = acet_pkg::READ_ZERO;
        if (bus.rd) begin
            if (bus.addr == acet_pkg::OFS_CHANNEL) begin
                s_nxt.rdata[acet_pkg::CHAN_LSB +: acet_pkg::CHAN_W] = s_r.chan;
                s_nxt.rdata[acet_pkg::GO_BIT] = s_r.go;
                s_nxt.rdata[acet_pkg::EN_BIT] = s_r.en;
            end else if (bus.addr == acet_pkg::OFS_REFERENCE) begin
                s_nxt.rdata[acet_pkg::VREF_LSB +: acet_pkg::VREF_W] = s_r.vref;
                s_nxt.rdata[acet_pkg::PCFG_LSB +: acet_pkg::PCFG_W] = s_r.pcfg;
            end else if (bus.addr == acet_pkg::OFS_TIMING) begin
                s_nxt.rdata[acet_pkg::JUST_BIT] = s_r.just;
                s_nxt.rdata[acet_pkg::ACQ_LSB +: acet_pkg::SEL_W]  = s_r.acq;
                s_nxt.rdata[acet_pkg::CLKS_LSB +: acet_pkg::SEL_W] = s_r.clks;
            end else if (bus.addr == acet_pkg::OFS_RES_HIGH) begin
                s_nxt.rdata = res_high;
            end else if (bus.addr == acet_pkg::OFS_RES_LOW) begin
                s_nxt.rdata = res_low;
            end else if (bus.addr == acet_pkg::OFS_IRQ_FLAGS) begin
                s_nxt.rdata[acet_pkg::IRQ_BIT] = s_r.irq_flag;
            end else if (bus.addr == acet_pkg::OFS_IRQ_EN) begin
                s_nxt.rdata[acet_pkg::IRQ_BIT] = s_r.irq_en;
            end else if (bus.addr == acet_pkg::OFS_IRQ_PRIO) begin
                s_nxt.rdata[acet_pkg::IRQ_BIT] = s_r.irq_prio;
            end else if (bus.addr == acet_pkg::OFS_TRIGGER) begin
                s_nxt.rdata[acet_pkg::TSEL_BIT] = s_r.trig_sel;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ============================================================
    // sequencer and result pair
    acet_seq #(
        .CONV_TADS    (CONV_TADS),
        .ACQ_TAD_STEP (ACQ_TAD_STEP)
    ) u_seq (
        .clock      (clock),
        .rst_sync_n (rst_sync_n),
        .start      (s_r.start),
        .abort      (s_r.abort),
        .acq_sel    (s_r.acq),
        .clk_sel    (s_r.clks),
        .sampling   (seq_sampling),
        .done       (seq_done)
    );

    acet_fmt u_fmt (
        .clock         (clock),
        .rst_sync_n    (rst_sync_n),
        .load          (seq_done),
        .justify_right (s_r.just),
        .raw           (sample_data),
        .wr_high       (acet_hit(bus.wr, bus.addr, acet_pkg::OFS_RES_HIGH)),
        .wr_low        (acet_hit(bus.wr, bus.addr, acet_pkg::OFS_RES_LOW)),
        .wdata         (bus.wdata),
        .result_high   (res_high),
        .result_low    (res_low)
    );

    // ============================================================
    // outputs
    assign rd_data           = s_r.rdata;
    assign first_timer_clear = s_r.clr1;
    assign third_timer_clear = s_r.clr3;

    assign analog.channel_select           = s_r.chan;
    assign analog.voltage_reference_select = s_r.vref;
    assign analog.port_analog_config       = s_r.pcfg;
    assign analog.sampling                 = seq_sampling;
    assign analog.converter_enable         = s_r.en;

    assign irq_request       = s_r.irq_flag && s_r.irq_en;
    assign irq_high_priority = s_r.irq_prio;

endmodule : acet_top

// file: tb/acet_top_assertions.sv
/*
 * concurrent checks on the ports of acet_top.
 * assumes one clock domain and the bind in the bench top file.
 */
`timescale 1ns/10ps
module acet_top_assertions (
    // clock and reset
    input wire logic                   clock,
    input wire logic                   rst_n,
    // watched ports
    input wire acet_pkg::acet_bus_s    bus,
    input wire acet_pkg::acet_byte_t   rd_data,
    input wire acet_pkg::acet_cmp_s    cmp,
    input wire logic                   first_timer_clear,
    input wire logic                   third_timer_clear,
    input wire acet_pkg::acet_analog_s analog
);
    // ============================================================
    // helpers
    logic evt;
    logic clr;
    assign evt = cmp.special_event && (cmp.compare_mode_field == acet_pkg::SPECIAL_EVENT_CODE);
    assign clr = first_timer_clear || third_timer_clear;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // ============================================================
    // checks
    chk_clear_follows_trigger: assert property (evt |=> clr)
        else $error("clear missing");
    chk_clear_has_cause: assert property (clr |-> $past(evt))
        else $error("clear without cause");
    chk_one_timer_only: assert property (!(first_timer_clear && third_timer_clear))
        else $error("both timers cleared");
    chk_clear_single_pulse: assert property (clr |=> !clr)
        else $error("clear too long");
    chk_control_top_zero: assert property (($past(bus.rd) && ($past(bus.addr) == acet_pkg::OFS_CHANNEL
        || $past(bus.addr) == acet_pkg::OFS_REFERENCE)) |-> rd_data[7:6] == 2'h0)
        else $error("control bits 7:6 set");
    chk_timing_gap_zero: assert property ($past(bus.rd) && $past(bus.addr) == acet_pkg::OFS_TIMING
        |-> !rd_data[6])
        else $error("timing bit 6 set");
    chk_irq_flag_only: assert property ($past(bus.rd) && $past(bus.addr) == acet_pkg::OFS_IRQ_FLAGS
        |-> (rd_data & 8'hBF) == 8'h00)
        else $error("stray flag bits");
    chk_disabled_no_sample: assert property (evt && !analog.converter_enable
        && !$past(analog.converter_enable) |-> ##2 !analog.sampling)
        else $error("sampling while off");
    cover property (evt ##1 third_timer_clear);
    cover property (evt ##1 first_timer_clear);
    cover property ($rose(analog.sampling));
endmodule : acet_top_assertions

// file: tb/acet_cmp_model.sv
/*
 * compare unit and timer model; fires on request or at the period.
 * assumes the block's clock.
 */
`timescale 1ns/10ps
module acet_cmp_model #(
    parameter int PERIOD = 40
) (
    // clock and reset
    input wire logic              clock,
    input wire logic              rst_n,
    // bench control
    input wire logic [3:0]        mode,
    input wire logic              periodic,
    input wire logic              fire,
    // timer clears from the block
    input wire logic              first_timer_clear,
    input wire logic              third_timer_clear,
    // toward the block
    output acet_pkg::acet_cmp_s   cmp,
    output acet_pkg::acet_result_t sample_data
);
    logic [7:0] count_r;
    logic       event_r;
    assign cmp = '{special_event: event_r, compare_mode_field: mode};
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_r     <= 8'h00;
            event_r     <= 1'b0;
            sample_data <= 10'h2A5;
        end else begin
            event_r <= fire || (periodic && count_r == 8'(PERIOD - 1));
            if (first_timer_clear || third_timer_clear) begin
                count_r     <= 8'h00;
                sample_data <= sample_data + 10'h0D3;
            end else begin
                count_r <= count_r + 8'h01;
            end
        end
    end
endmodule : acet_cmp_model

// file: tb/test_acet_top.sv
/*
 * bench for acet_top with compare model and checker bind.
 * assumes short sequencer counts at the instance.
 */
`timescale 1ns/10ps
module test_acet_top;
    logic                   clock = 1'b0, rst_n = 1'b0, periodic = 1'b0, fire = 1'b0, rd_seen = 1'b0;
    logic [3:0]             mode = 4'h0;
    acet_pkg::acet_bus_s    bus = '0;
    acet_pkg::acet_byte_t   rd_data;
    acet_pkg::acet_cmp_s    cmp;
    acet_pkg::acet_result_t sample_data, s;
    acet_pkg::acet_analog_s analog;
    logic                   first_timer_clear, third_timer_clear, irq_request, irq_high_priority;
    logic [15:0]            note_q[$], note, r = 16'h377A;
    int                     num_errors = 0, checks = 0, n_first = 0, n_third = 0, f0, t0;
    acet_top #(.CONV_TADS(2), .ACQ_TAD_STEP(1)) u_dut (.clock, .rst_n, .bus, .rd_data, .cmp,
        .first_timer_clear, .third_timer_clear, .sample_data, .analog, .irq_request,
        .irq_high_priority);
    acet_cmp_model #(.PERIOD(40)) u_cmp (.clock, .rst_n, .mode, .periodic, .fire,
        .first_timer_clear, .third_timer_clear, .cmp, .sample_data);
    initial forever #20 clock = ~clock;
    // ============================================================
    // tasks
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic access(input logic w, input acet_pkg::acet_addr_t a, input acet_pkg::acet_byte_t d);
        @(posedge clock);
        bus <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clock);
        bus <= '0;
    endtask : access
    // mask and expected value noted before the strobe
    task automatic rd(input acet_pkg::acet_addr_t a, input acet_pkg::acet_byte_t m,
                      input acet_pkg::acet_byte_t e);
        note_q.push_back({m, e});
        access(1'b0, a, 8'h00);
    endtask : rd
    task automatic trigger(input logic [3:0] m);
        @(posedge clock);
        mode <= m;
        fire <= 1'b1;
        @(posedge clock);
        fire <= 1'b0;
    endtask : trigger
    task automatic wait_irq();
        for (int i = 0; i < 600 && irq_request !== 1'b1; i++) @(negedge clock);
        check(irq_request, 1'b1);
        s = sample_data;
    endtask : wait_irq
    // ============================================================
    // read data watcher and clear counters
    always @(posedge clock) begin
        n_first += first_timer_clear;
        n_third += third_timer_clear;
        if (rd_seen) begin
            note = note_q.pop_front();
            check(rd_data & note[15:8], note[7:0]);
        end
        rd_seen <= bus.rd;
    end
    initial begin
        #800000;
        num_errors++;
        end_sim();
    end
    // ============================================================
    // main sequence
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        for (int a = 0; a < 10; a++) rd(4'(a), 8'hFF, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            r = lfsr(r);
            access(1'b1, acet_pkg::OFS_REFERENCE, r[7:0]);
            access(1'b1, acet_pkg::OFS_TIMING, r[7:0]);
            access(1'b1, acet_pkg::OFS_IRQ_PRIO, r[7:0]);
            access(1'b1, acet_pkg::OFS_CHANNEL, r[7:0] & 8'h3C);
            rd(acet_pkg::OFS_REFERENCE, 8'hFF, r[7:0] & 8'h3F);
            rd(acet_pkg::OFS_TIMING, 8'hFF, r[7:0] & 8'hBF);
            rd(acet_pkg::OFS_IRQ_PRIO, 8'hFF, r[7:0] & 8'h40);
            rd(acet_pkg::OFS_CHANNEL, 8'hFF, r[7:0] & 8'h3C);
            check({analog.voltage_reference_select, analog.port_analog_config}, r[5:0]);
            check(analog.channel_select, r[5:2]);
            check(irq_high_priority, r[6]);
        end
        $display("test layout done");
        // channel and acquisition time set before any trigger
        access(1'b1, acet_pkg::OFS_TIMING, 8'h88);
        access(1'b1, acet_pkg::OFS_TRIGGER, 8'h01);
        access(1'b1, acet_pkg::OFS_IRQ_EN, 8'h40);
        access(1'b1, acet_pkg::OFS_CHANNEL, 8'h15);
        t0 = n_third;
        for (int m = 0; m < 16; m++) begin
            trigger(4'(m));
            rd(acet_pkg::OFS_CHANNEL, 8'h02, (4'(m) == acet_pkg::SPECIAL_EVENT_CODE) ? 8'h02 : 8'h00);
            if (4'(m) == acet_pkg::SPECIAL_EVENT_CODE) begin
                wait_irq();
                // result bytes moved before the next trigger
                rd(acet_pkg::OFS_RES_HIGH, 8'hFF, {6'h00, s[9:8]});
                rd(acet_pkg::OFS_RES_LOW, 8'hFF, s[7:0]);
                rd(acet_pkg::OFS_CHANNEL, 8'h02, 8'h00);
                rd(acet_pkg::OFS_IRQ_FLAGS, 8'hFF, 8'h40);
                access(1'b1, acet_pkg::OFS_IRQ_FLAGS, 8'h00);
            end
        end
        repeat (2) @(posedge clock);
        check(16'(n_third - t0), 16'h0001);
        $display("test modes done");
        access(1'b1, acet_pkg::OFS_CHANNEL, 8'h14);
        access(1'b1, acet_pkg::OFS_TRIGGER, 8'h00);
        f0 = n_first;
        trigger(acet_pkg::SPECIAL_EVENT_CODE);
        rd(acet_pkg::OFS_CHANNEL, 8'h03, 8'h00);
        repeat (20) @(posedge clock);
        check(irq_request, 1'b0);
        check(16'(n_first - f0), 16'h0001);
        $display("test disabled done");
        // left justified results, timer restarted by each trigger
        access(1'b1, acet_pkg::OFS_TIMING, 8'h08);
        access(1'b1, acet_pkg::OFS_CHANNEL, 8'h15);
        periodic <= 1'b1;
        repeat (2) begin
            wait_irq();
            rd(acet_pkg::OFS_RES_HIGH, 8'hFF, s[9:2]);
            rd(acet_pkg::OFS_RES_LOW, 8'hFF, {s[1:0], 6'h00});
            access(1'b1, acet_pkg::OFS_IRQ_FLAGS, 8'h00);
        end
        periodic <= 1'b0;
        $display("test periodic done");
        end_sim();
    end
endmodule : test_acet_top
bind acet_top acet_top_assertions u_chk (.clock, .rst_n, .bus, .rd_data, .cmp,
    .first_timer_clear, .third_timer_clear, .analog);
